// ===== core/crms_pkg.sv
// Constants, types and register map of the core regulator mode sequencer.
// Assumes one 125 MHz clock, a synchronous active-high reset that also
// stands for the supply power-on reset, and a slew tick from outside logic.
//
// Notes on behaviour
// - During the shutdown ramp the target code moves by exactly one code (25mV) per step.
// - During the shutdown ramp the code falls by one step every four slew ticks.
// - The shutdown ramp starts from the code in force when the sequence begins.
// - When the shutdown ramp reaches the zero code the low-side gate is forced high, the high-side gate low and the reference off.
// - An undervoltage, overvoltage or thermal fault starts the shutdown and sets a fault latch that holds the target at zero and blocks restart.
// - The fault latch clears only on an enable toggle or on power-on reset, and then a restart is allowed.
// - While enable is low the low-side gate is high, the high-side gate low and switching is off, whatever the other inputs.
// - Enabled with suspend select at ground and no offset requested, the target is table select plus the five-bit VID code.
// - With pulse-skip select at reference or ground in normal or deep-sleep mode, light-load skipping is allowed and the upper power-good check is blanked.
// - In deep sleep (suspend select at ground, offset select high) the target is table select plus the VID code plus the programmed offset.
// - Suspend select at reference or high takes the target from the suspend code with no offset, above every mode but off and fault.
// - Power-good stays low until at least 3ms after the ramp reaches the target code.
// - When enable goes low power-good drops at once, before the ramp down.
// - Suspend select at reference picks the upper suspend range, high picks the lower range.
package crms_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS  = 8;
  localparam int PG_DELAY_NS    = 3000000;
  localparam int PG_DELAY_CYC   = (PG_DELAY_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int ENABLE_IN_TICKS     = 4;
  localparam int DAC_LSB_MV     = 25;

  // ==========================================================================
  // Widths and reset values
  localparam int DAC_W          = 7;
  localparam int PG_CNT_W       = 20;
  localparam logic [6:0]  DAC_RESET  = 7'h00;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] CFG_RESET  = 32'h0000_0000;

  // ==========================================================================
  // Multi-level input codes
  localparam logic [1:0] LVL_GND  = 2'h0;
  localparam logic [1:0] LVL_REF  = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [1:0] LVL_OPEN = 2'h3;

  // Suspend range bases, added to the four-bit suspend code.
  localparam logic [6:0] SUS_UPPER_BASE = 7'h20;
  localparam logic [6:0] SUS_LOWER_BASE = 7'h10;

  // ==========================================================================
  // Register map (byte addresses) and fields
  localparam logic [7:0] REG_STATUS   = 8'h00;
  localparam logic [7:0] REG_IRQ_STAT = 8'h04;
  localparam logic [7:0] REG_IRQ_MASK = 8'h08;
  localparam logic [7:0] REG_CONFIG   = 8'h0C;
  localparam int CFG_TABLE_BIT  = 0;
  localparam int CFG_OFS_LSB    = 1;
  localparam int CFG_OFS_W      = 4;
  localparam int IRQ_W          = 4;
  localparam int IRQ_FAULT      = 0;
  localparam int IRQ_PG_RISE    = 1;
  localparam int IRQ_PG_FALL    = 2;
  localparam int IRQ_PARKED     = 3;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    ST_OFF  = 2'h0,
    ST_RUN  = 2'h1,
    ST_DOWN = 2'h3
  } crms_state_t;

  typedef enum logic [2:0] {
    MODE_DISABLED = 3'h0,
    MODE_FAULT    = 3'h1,
    MODE_SUSPEND  = 3'h3,
    MODE_DEEP     = 3'h2,
    MODE_NORMAL   = 3'h6
  } crms_mode_t;

endpackage

// ===== core/crms_sync2.sv
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/10ps
module crms_sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_clock,  // System clock.
  input  wire logic         i_reset,  // Synchronous reset, active high.
  input  wire logic [W-1:0] i_async,  // Levels from pins.
  output logic      [W-1:0] o_sync    // Levels in the clock domain.
);
  logic [W-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

// ===== core/crms_top.sv
// Mode decoder, fault latch and soft-shutdown sequencer with register port.
// Assumes pins pass the local synchroniser and the slew tick is a one-cycle
// pulse from logic on the same clock.
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/10ps
module crms_top
  import crms_pkg::*;
#(
  parameter int PG_CYCLES = PG_DELAY_CYC
) (
  input  wire logic        i_clock,             // 125 MHz clock.
  input  wire logic        i_reset,             // Sync reset / power-on.
  input  wire logic        i_slew_tick,         // One-cycle slew tick.
  input  wire logic        i_enable_in,         // Enable pin.
  input  wire logic [1:0]  i_suspend_select,    // Level code.
  input  wire logic [1:0]  i_pulse_skip_select, // Level code.
  input  wire logic        i_offset_select,     // Deep-sleep offset on.
  input  wire logic [4:0]  i_vid_code,          // VID code.
  input  wire logic [3:0]  i_suspend_code,      // Two level codes.
  input  wire logic        i_undervoltage_fault, // Comparator level.
  input  wire logic        i_overvoltage_fault,  // Comparator level.
  input  wire logic        i_thermal_fault,      // Comparator level.
  input  wire logic [7:0]  i_addr,              // Register byte address.
  input  wire logic [31:0] i_wr_data,           // Write data.
  input  wire logic        i_wr_strobe,         // Write strobe.
  input  wire logic        i_rd_strobe,         // Read strobe.
  output logic [31:0]      o_rd_data,           // Read data, next cycle.
  output logic [6:0]       o_dac_code,          // DAC target code.
  output logic             o_reference_on,      // Reference enable.
  output logic             o_low_side_gate,     // Low-side forced on.
  output logic             o_high_side_gate,    // High-side allowed.
  output logic             o_pulse_skip_en,     // Light-load skipping.
  output logic             o_upper_pg_blank,    // Upper check blanked.
  output logic             o_power_good,        // Power good.
  output logic             o_fault_latched,     // Fault latch.
  output logic             o_irq                // Level interrupt.
);

  // ==========================================================================
  // Pin synchronisation
  localparam int SYNC_W = 18;
  logic [SYNC_W-1:0] sync_w;
  logic        en_s;
  logic [1:0]  sus_s;
  logic [1:0]  skip_s;
  logic        ofs_s;
  logic [4:0]  vid_s;
  logic [3:0]  scode_s;
  logic [2:0]  faults_s;

  crms_sync2 #(.W(SYNC_W)) u_sync (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .i_async ({i_enable_in, i_suspend_select, i_pulse_skip_select,
               i_offset_select, i_vid_code, i_suspend_code,
               i_undervoltage_fault, i_overvoltage_fault, i_thermal_fault}),
    .o_sync  (sync_w)
  );

  assign {en_s, sus_s, skip_s, ofs_s, vid_s, scode_s, faults_s} = sync_w;

  // ==========================================================================
  // State
  crms_state_t       st_q, st_d;
  logic [6:0]        dac_q, dac_d;
  logic [1:0]        div_q, div_d;
  logic              fault_q, fault_d;
  logic              en_q;
  logic              pg_q, pg_d;
  logic [PG_CNT_W-1:0] pg_cnt_q, pg_cnt_d;
  logic [IRQ_W-1:0]  irq_stat_q, irq_stat_d;
  logic [IRQ_W-1:0]  irq_mask_q;
  logic [31:0]       cfg_q;

  localparam logic [1:0] DIV_LAST = 2'(ENABLE_IN_TICKS - 1);
  localparam logic [PG_CNT_W-1:0] PG_LAST = PG_CNT_W'(PG_CYCLES - 1);

  // ==========================================================================
  // Mode decode
  function automatic logic [6:0] calc_target(
    input crms_mode_t  mode,
    input logic        table_sel,
    input logic [4:0]  vid,
    input logic [3:0]  offs,
    input logic [1:0]  suspend_select,
    input logic [3:0]  scode
  );
    logic [6:0] t;
    t = 7'h00;
    case (mode)
      MODE_NORMAL: t = {1'b0, table_sel, vid};
      MODE_DEEP:   t = {1'b0, table_sel, vid} + {3'h0, offs};
      MODE_SUSPEND: begin
        if (suspend_select == LVL_REF) begin
          t = SUS_UPPER_BASE + {3'h0, scode};
        end else begin
          t = SUS_LOWER_BASE + {3'h0, scode};
        end
      end
      default: t = 7'h00;
    endcase
    return t;
  endfunction

  logic       sus_active_w;
  logic       skip_sel_w;
  logic       fault_in_w;
  logic       fault_evt_w;
  logic       en_rise_w;
  crms_mode_t mode_w;
  logic [6:0] target_w;
  logic       step_w;
  logic       park_w;
  logic       pg_cond_w;

  assign sus_active_w = (sus_s == LVL_REF) || (sus_s == LVL_HIGH);
  assign skip_sel_w   = (skip_s == LVL_REF) || (skip_s == LVL_GND);
  assign fault_in_w   = |faults_s;
  assign fault_evt_w  = fault_in_w && (st_q == ST_RUN);
  assign en_rise_w    = en_s && !en_q;

  // A disabled or faulted controller targets ground.
  assign mode_w = !en_s        ? MODE_DISABLED :
                  fault_q      ? MODE_FAULT    :
                  sus_active_w ? MODE_SUSPEND  :
                  ofs_s        ? MODE_DEEP     :
                                 MODE_NORMAL;

  assign target_w = calc_target(mode_w, cfg_q[CFG_TABLE_BIT], vid_s,
                                cfg_q[CFG_OFS_LSB +: CFG_OFS_W],
                                sus_s, scode_s);

  assign step_w = i_slew_tick && (div_q == DIV_LAST)
                  && (dac_q != 7'h00);
  assign park_w = (st_q == ST_OFF) || !en_s;

  // A voltage change restarts the power-good delay.
  assign pg_cond_w = en_s && !fault_q && (st_q == ST_RUN)
                     && (dac_q == target_w);

  // ==========================================================================
  // Sequencer
  always_comb begin
    st_d  = st_q;
    dac_d = dac_q;
    div_d = 2'h0;
    case (st_q)
      ST_OFF: begin
        if (en_s && !fault_q) begin
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!en_s || fault_evt_w) begin
          st_d = ST_DOWN;
        end else if (i_slew_tick && (dac_q < target_w)) begin
          dac_d = dac_q + 7'h01;
        end else if (i_slew_tick && (dac_q > target_w)) begin
          dac_d = dac_q - 7'h01;
        end
      end
      ST_DOWN: begin
        div_d = i_slew_tick ? div_q + 2'h1 : div_q;
        if (dac_q == 7'h00) begin
          st_d = ST_OFF;
        end else if (step_w) begin
          dac_d = dac_q - 7'h01;
        end
      end
      default: begin
        st_d  = ST_OFF;
        dac_d = DAC_RESET;
      end
    endcase
  end

  // The set wins over the enable-toggle clear.
  assign fault_d = fault_evt_w ? 1'b1 :
                   en_rise_w   ? 1'b0 : fault_q;

  assign pg_cnt_d = !pg_cond_w          ? '0 :
                    (pg_cnt_q == PG_LAST) ? pg_cnt_q :
                    pg_cnt_q + PG_CNT_W'(1);
  assign pg_d = pg_cond_w && (pg_cnt_q == PG_LAST);

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      st_q     <= ST_OFF;
      dac_q    <= DAC_RESET;
      div_q    <= 2'h0;
      fault_q  <= 1'b0;
      en_q     <= 1'b0;
      pg_q     <= 1'b0;
      pg_cnt_q <= '0;
    end else begin
      st_q     <= st_d;
      dac_q    <= dac_d;
      div_q    <= div_d;
      fault_q  <= fault_d;
      en_q     <= en_s;
      pg_q     <= pg_d;
      pg_cnt_q <= pg_cnt_d;
    end
  end

  // ==========================================================================
  // Registered outputs
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_low_side_gate  <= 1'b1;
      o_high_side_gate <= 1'b0;
      o_reference_on   <= 1'b0;
      o_pulse_skip_en  <= 1'b0;
      o_upper_pg_blank <= 1'b0;
    end else begin
      o_low_side_gate  <= park_w;
      o_high_side_gate <= !park_w;
      o_reference_on   <= (st_q != ST_OFF);
      o_pulse_skip_en  <= skip_sel_w && ((mode_w == MODE_NORMAL)
                          || (mode_w == MODE_DEEP));
      o_upper_pg_blank <= skip_sel_w && ((mode_w == MODE_NORMAL)
                          || (mode_w == MODE_DEEP));
    end
  end

  assign o_dac_code      = dac_q;
  assign o_power_good    = pg_q;
  assign o_fault_latched = fault_q;

  // ==========================================================================
  // Register port and interrupts
  logic [IRQ_W-1:0] irq_evt_w;
  logic             rd_irq_w;
  logic [31:0]      rd_mux_w;

  assign irq_evt_w[IRQ_FAULT]   = fault_evt_w && !fault_q;
  assign irq_evt_w[IRQ_PG_RISE] = pg_d && !pg_q;
  assign irq_evt_w[IRQ_PG_FALL] = !pg_d && pg_q;
  assign irq_evt_w[IRQ_PARKED]  = (st_q == ST_DOWN) && (st_d == ST_OFF);
  assign rd_irq_w = i_rd_strobe && (i_addr == REG_IRQ_STAT);

  // An event in the clearing read cycle survives.
  assign irq_stat_d = (rd_irq_w ? '0 : irq_stat_q) | irq_evt_w;

  assign rd_mux_w = (i_addr == REG_STATUS)   ?
                      {18'h0, st_q, pg_q, fault_q, mode_w, dac_q} :
                    (i_addr == REG_IRQ_STAT) ? {28'h0, irq_stat_q} :
                    (i_addr == REG_IRQ_MASK) ? {28'h0, irq_mask_q} :
                    (i_addr == REG_CONFIG)   ?
                      {27'h0, cfg_q[CFG_OFS_LSB +: CFG_OFS_W],
                       cfg_q[CFG_TABLE_BIT]} :
                    32'h0000_0000;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      irq_stat_q <= '0;
      irq_mask_q <= MASK_RESET[IRQ_W-1:0];
      cfg_q      <= CFG_RESET;
      o_rd_data  <= 32'h0000_0000;
      o_irq      <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      if (i_wr_strobe && (i_addr == REG_IRQ_MASK)) begin
        irq_mask_q <= i_wr_data[IRQ_W-1:0];
      end
      if (i_wr_strobe && (i_addr == REG_CONFIG)) begin
        cfg_q <= {27'h0, i_wr_data[4:0]};
      end
      o_rd_data <= i_rd_strobe ? rd_mux_w : 32'h0000_0000;
      o_irq     <= |(irq_stat_d & irq_mask_q);
    end
  end

  // ==========================================================================
  // Assertions
  property p_step_one;
    @(posedge i_clock) disable iff (i_reset)
    (st_q == ST_DOWN) |=> (dac_q == $past(dac_q))
      || (dac_q == $past(dac_q) - 7'h01);
  endproperty
  a_step_one: assert property (p_step_one)
    else $error("ramp step is not one code");

  property p_four_ticks;
    @(posedge i_clock) disable iff (i_reset)
    (st_q == ST_DOWN) && !(i_slew_tick && (div_q == 2'h3)) |=> $stable(dac_q);
  endproperty
  a_four_ticks: assert property (p_four_ticks)
    else $error("ramp stepped before fourth tick");

  property p_ramp_start;
    @(posedge i_clock) disable iff (i_reset)
    (st_q == ST_RUN) && !en_s |=> (st_q == ST_DOWN) && $stable(dac_q);
  endproperty
  a_ramp_start: assert property (p_ramp_start)
    else $error("ramp did not start from current code");

  property p_park;
    @(posedge i_clock) disable iff (i_reset)
    (st_q == ST_DOWN) && (dac_q == 7'h00) |=> ##1
      (o_low_side_gate && !o_high_side_gate && !o_reference_on);
  endproperty
  a_park: assert property (p_park)
    else $error("gates not parked at zero code");

  property p_fault_set;
    @(posedge i_clock) disable iff (i_reset)
    fault_in_w && (st_q == ST_RUN) |=> fault_q && (st_q == ST_DOWN);
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("fault did not latch and start shutdown");

  property p_fault_hold;
    @(posedge i_clock) disable iff (i_reset)
    fault_q && !en_rise_w |=> fault_q && (st_q != ST_RUN);
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("fault latch cleared without toggle");

  property p_disabled;
    @(posedge i_clock) disable iff (i_reset)
    !en_s |=> o_low_side_gate && !o_high_side_gate;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("gates not parked while disabled");

  property p_suspend_wins;
    @(posedge i_clock) disable iff (i_reset)
    en_s && !fault_q && sus_active_w |-> (target_w ==
      (((sus_s == LVL_REF) ? SUS_UPPER_BASE : SUS_LOWER_BASE)
       + {3'h0, scode_s}));
  endproperty
  a_suspend_wins: assert property (p_suspend_wins)
    else $error("suspend did not override");

  property p_pg_delay;
    @(posedge i_clock) disable iff (i_reset)
    $rose(pg_q) |-> $past(pg_cond_w, 2) && (pg_cnt_q == PG_LAST);
  endproperty
  a_pg_delay: assert property (p_pg_delay)
    else $error("power good rose before delay");

  property p_pg_drop;
    @(posedge i_clock) disable iff (i_reset)
    !en_s |=> !o_power_good;
  endproperty
  a_pg_drop: assert property (p_pg_drop)
    else $error("power good not dropped on disable");

endmodule

// ===== verif/crms_cpu_model.sv
// Far-side model: slew-rate clock divider and the power switch stage.
// Assumes the sequencer's clock and synchronous reset.
`timescale 1ns/10ps
module crms_cpu_model #(
  parameter int TP = 4
) (
  input  wire logic i_clock,          // System clock.
  input  wire logic i_reset,          // Sync reset.
  input  wire logic i_low_side_gate,  // Low-side drive.
  input  wire logic i_high_side_gate, // High-side drive.
  output logic      o_slew_tick,      // One-cycle slew tick.
  output logic      o_shoot_through   // Both switches on.
);
  // ==========================================================
  // Slew clock
  int cnt_q;
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      cnt_q       <= 0;
      o_slew_tick <= 1'b0;
    end else begin
      cnt_q       <= (cnt_q == TP - 1) ? 0 : cnt_q + 1;
      o_slew_tick <= (cnt_q == TP - 1);
    end
  end
  // Both switches on would short the supply, so it is flagged.
  assign o_shoot_through = i_low_side_gate & i_high_side_gate;
endmodule

// ===== verif/test_core_regulator_mode_sequencer.sv
// Self-checking testbench of the mode sequencer.
// Assumes the core package, the sequencer and the far-side model.
`timescale 1ns/10ps
module test_core_regulator_mode_sequencer;
  import crms_pkg::*;
  localparam int PGC = 20;
  localparam int TP  = 4;
  logic        i_clock = 1'b0;
  logic        i_reset = 1'b1;
  logic        i_enable_in = 1'b0;
  logic [1:0]  i_suspend_select = LVL_GND;
  logic [1:0]  i_pulse_skip_select = LVL_HIGH;
  logic        i_offset_select = 1'b0;
  logic [4:0]  i_vid_code = 5'h0E;
  logic [3:0]  i_suspend_code = 4'h5;
  logic        i_undervoltage_fault = 1'b0;
  logic        i_overvoltage_fault = 1'b0;
  logic        i_thermal_fault = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wr_data = 32'h0;
  logic        i_wr_strobe = 1'b0;
  logic        i_rd_strobe = 1'b0;
  logic        i_slew_tick;
  logic [31:0] o_rd_data;
  logic [6:0]  o_dac_code;
  logic        o_reference_on, o_low_side_gate, o_high_side_gate;
  logic        o_pulse_skip_en, o_upper_pg_blank, o_power_good;
  logic        o_fault_latched, o_irq, shoot;
  logic [31:0] rdv;
  int          errors = 0;
  int          compares = 0;

  always #4 i_clock = ~i_clock;

  crms_top #(.PG_CYCLES(PGC)) crms_top_inst (
    .i_clock, .i_reset, .i_slew_tick, .i_enable_in, .i_suspend_select,
    .i_pulse_skip_select, .i_offset_select, .i_vid_code, .i_suspend_code,
    .i_undervoltage_fault, .i_overvoltage_fault, .i_thermal_fault,
    .i_addr, .i_wr_data, .i_wr_strobe, .i_rd_strobe, .o_rd_data,
    .o_dac_code, .o_reference_on, .o_low_side_gate, .o_high_side_gate,
    .o_pulse_skip_en, .o_upper_pg_blank, .o_power_good,
    .o_fault_latched, .o_irq);

  crms_cpu_model #(.TP(TP)) crms_cpu_model_inst (
    .i_clock, .i_reset, .i_low_side_gate(o_low_side_gate),
    .i_high_side_gate(o_high_side_gate), .o_slew_tick(i_slew_tick),
    .o_shoot_through(shoot));

  // ==========================================================
  // Shared tasks
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    compares++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic hang(string n);
    errors++;
    $display("[ERR] %s exp done got timeout", n);
    tally_and_finish();
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge i_clock);
    i_addr      <= a;
    i_wr_data   <= d;
    i_wr_strobe <= 1'b1;
    @(posedge i_clock);
    i_wr_strobe <= 1'b0;
  endtask

  task automatic rd_reg(logic [7:0] a);
    @(posedge i_clock);
    i_addr      <= a;
    i_rd_strobe <= 1'b1;
    @(posedge i_clock);
    i_rd_strobe <= 1'b0;
    #1;
    rdv = o_rd_data;
  endtask

  task automatic wait_dac(logic [6:0] v);
    int n;
    n = 0;
    while (o_dac_code !== v) begin
      tick(1);
      n++;
      if (n > 3000) hang("dac");
    end
  endtask

  // Gates must never both be on once out of reset.
  always @(negedge i_clock) if (!i_reset) chk("shoot", 0, shoot);

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk("dac", 0, o_dac_code);
    chk("low", 1, o_low_side_gate);
    chk("high", 0, o_high_side_gate);
    chk("ref", 0, o_reference_on);
    chk("pg", 0, o_power_good);
    rd_reg(REG_CONFIG);
    chk("cfg", CFG_RESET, rdv);
    rd_reg(REG_IRQ_MASK);
    chk("mask", MASK_RESET, rdv);
    rd_reg(8'h10);
    chk("unmapped", 0, rdv);
    $display("test reset done");
  endtask

  task automatic t_normal();
    wr_reg(REG_CONFIG, 32'h0000_0007);
    i_enable_in <= 1'b1;
    wait_dac(7'h2E);
    chk("skip", 0, o_pulse_skip_en);
    tick(PGC - 1);
    chk("pg_hold", 0, o_power_good);
    for (int i = 0; i < 10 && o_power_good !== 1'b1; i++) tick(1);
    chk("pg_up", 1, o_power_good);
    rd_reg(REG_IRQ_STAT);
    chk("pg_rise", 1, rdv[IRQ_PG_RISE]);
    rd_reg(REG_STATUS);
    chk("mode", MODE_NORMAL, rdv[9:7]);
    chk("stat_dac", 7'h2E, rdv[6:0]);
    i_pulse_skip_select <= LVL_REF;
    tick(6);
    chk("skip_ref", 1, o_pulse_skip_en);
    chk("blank_ref", 1, o_upper_pg_blank);
    i_pulse_skip_select <= LVL_GND;
    tick(6);
    chk("skip_gnd", 1, o_pulse_skip_en);
    chk("blank_gnd", 1, o_upper_pg_blank);
    $display("test normal done");
  endtask

  task automatic t_deep();
    i_offset_select <= 1'b1;
    wait_dac(7'h31);
    rd_reg(REG_STATUS);
    chk("mode", MODE_DEEP, rdv[9:7]);
    chk("skip", 1, o_pulse_skip_en);
    $display("test deep done");
  endtask

  task automatic t_suspend();
    i_suspend_select <= LVL_REF;
    wait_dac(7'h25);
    rd_reg(REG_STATUS);
    chk("mode", MODE_SUSPEND, rdv[9:7]);
    chk("skip_sus", 0, o_pulse_skip_en);
    i_suspend_select <= LVL_HIGH;
    wait_dac(7'h15);
    chk("dac", 7'h15, o_dac_code);
    $display("test suspend done");
  endtask

  task automatic t_shutdown();
    logic [6:0] prev;
    int         n;
    bit         first;
    wr_reg(REG_IRQ_MASK, 32'h0000_0008);
    rd_reg(REG_IRQ_STAT);
    // Power-good must be up first, or the drop below proves nothing.
    for (int i = 0; i < 40 && o_power_good !== 1'b1; i++) tick(1);
    chk("pg_pre", 1, o_power_good);
    i_enable_in <= 1'b0;
    tick(3);
    chk("pg", 0, o_power_good);
    chk("low", 1, o_low_side_gate);
    chk("high", 0, o_high_side_gate);
    chk("start", 7'h15, o_dac_code);
    prev = 7'h15;
    n = 0;
    first = 1;
    while (prev != 7'h00) begin
      tick(1);
      n++;
      if (n > 200) hang("ramp");
      if (o_dac_code !== prev) begin
        chk("step", prev - 7'h01, o_dac_code);
        if (!first) chk("gap", 4 * TP, n);
        first = 0;
        n = 0;
        prev = o_dac_code;
      end
    end
    tick(3);
    chk("ref_off", 0, o_reference_on);
    chk("low", 1, o_low_side_gate);
    chk("irq", 1, o_irq);
    rd_reg(REG_IRQ_STAT);
    chk("parked", 1, rdv[IRQ_PARKED]);
    chk("pg_fall", 1, rdv[IRQ_PG_FALL]);
    tick(2);
    chk("irq_clr", 0, o_irq);
    $display("test shutdown done");
  endtask

  task automatic t_fault();
    i_suspend_select <= LVL_GND;
    i_offset_select  <= 1'b0;
    i_vid_code       <= 5'h06;
    wr_reg(REG_CONFIG, 32'h0);
    for (int k = 0; k < 3; k++) begin
      i_enable_in <= 1'b1;
      wait_dac(7'h06);
      {i_thermal_fault, i_overvoltage_fault, i_undervoltage_fault} <=
        3'h1 << k;
      tick(6);
      chk("latch", 1, o_fault_latched);
      rd_reg(REG_IRQ_STAT);
      chk("irq_fault", 1, rdv[IRQ_FAULT]);
      wait_dac(7'h00);
      {i_thermal_fault, i_overvoltage_fault, i_undervoltage_fault} <=
        3'h0;
      tick(30);
      chk("held", 0, o_dac_code);
      chk("low", 1, o_low_side_gate);
      chk("still", 1, o_fault_latched);
      i_enable_in <= 1'b0;
      tick(6);
      i_enable_in <= 1'b1;
      wait_dac(7'h06);
      chk("cleared", 0, o_fault_latched);
    end
    // A power-on reset in mid-run is the other way out of the latch.
    i_thermal_fault <= 1'b1;
    tick(6);
    chk("latch_por", 1, o_fault_latched);
    i_thermal_fault <= 1'b0;
    i_reset <= 1'b1;
    tick(3);
    chk("por_clear", 0, o_fault_latched);
    i_reset <= 1'b0;
    wait_dac(7'h06);
    chk("por_run", 0, o_fault_latched);
    $display("test fault done");
  endtask

  initial begin
    repeat (16) @(posedge i_clock);
    i_reset <= 1'b0;
    tick(1);
    t_reset();
    t_normal();
    t_deep();
    t_suspend();
    t_shutdown();
    t_fault();
    tally_and_finish();
  end
endmodule
